// *** logic/idle_insert_pkg.sv ***
// constants for the bus idle-cycle insertion block
package idle_insert_pkg;
  localparam int num_spaces = 8;
  localparam int space_w = 3;
  localparam int idle_cnt_w = 2;
  // configuration bit positions
  localparam int pair37_bit = 7;
  localparam int pair26_bit = 6;
  // reset values
  localparam logic pair37_idle_reset = 1'b1;
  localparam logic pair26_idle_reset = 1'b1;
  localparam logic [1:0] rw_idle_reset = 2'h3;
  // space numbers of the two pairs
  localparam logic [2:0] space_2 = 3'h2;
  localparam logic [2:0] space_3 = 3'h3;
  localparam logic [2:0] space_6 = 3'h6;
  localparam logic [2:0] space_7 = 3'h7;
  // pair indexes for the read-to-write setting
  localparam int pair_idx_w = 2;
  localparam logic [1:0] pair26_idx = 2'h2;
  localparam logic [1:0] pair37_idx = 2'h3;
endpackage

// *** logic/idle_need_calc.sv ***
// idle count needed between the previous and next access
`timescale 1ns/1ps
`default_nettype none
module idle_need_calc (
  // previous access
  input wire logic i_prev_valid,
  input wire logic [2:0] i_prev_space,
  input wire logic i_prev_read,
  // next access
  input wire logic [2:0] i_next_space,
  input wire logic i_next_write,
  // settings
  input wire logic i_pair37_idle_enable,
  input wire logic i_pair26_idle_enable,
  input wire logic [1:0] i_rtw_pair37,
  input wire logic [1:0] i_rtw_pair26,
  // result
  output logic [1:0] o_need
);
  wire logic prev_in37;
  wire logic prev_in26;
  wire logic next_in37;
  wire logic next_in26;
  wire logic consec37;
  wire logic consec26;
  wire logic [1:0] consecutive_idle_setting;
  wire logic [1:0] read_to_write_idle_count;
  wire logic rtw_applies;
  // pair membership
  assign prev_in37 = (i_prev_space == idle_insert_pkg::space_3) ||
                     (i_prev_space == idle_insert_pkg::space_7);
  assign prev_in26 = (i_prev_space == idle_insert_pkg::space_2) ||
                     (i_prev_space == idle_insert_pkg::space_6);
  assign next_in37 = (i_next_space == idle_insert_pkg::space_3) ||
                     (i_next_space == idle_insert_pkg::space_7);
  assign next_in26 = (i_next_space == idle_insert_pkg::space_2) ||
                     (i_next_space == idle_insert_pkg::space_6);
  // consecutive pair access, both spaces and both orders
  assign consec37 = i_prev_valid && prev_in37 && next_in37; // [RULE1] [RULE2] [RULE9]
  assign consec26 = i_prev_valid && prev_in26 && next_in26; // [RULE3] [RULE4] [RULE9]
  // 0 gives none, 1 gives exactly one
  assign consecutive_idle_setting = {1'b0, (consec37 && i_pair37_idle_enable) ||
                                    (consec26 && i_pair26_idle_enable)}; // [RULE5]
  // after read: write to same pair, or any access outside the pair
  assign rtw_applies = i_prev_valid && i_prev_read &&
                       (((prev_in37 && next_in37) || (prev_in26 && next_in26)) ?
                        i_next_write : 1'b1); // [RULE8]
  assign read_to_write_idle_count = !rtw_applies ? 2'h0 :
                                    prev_in37 ? i_rtw_pair37 :
                                    prev_in26 ? i_rtw_pair26 : 2'h0; // [RULE8]
  // larger of the two
  assign o_need = (read_to_write_idle_count > consecutive_idle_setting) ?
                  read_to_write_idle_count : consecutive_idle_setting; // [RULE7]
endmodule // idle_need_calc
`default_nettype wire

// *** logic/bus_idle_cycle_insertion.sv ***
// idle-cycle insertion between external bus accesses on spaces 2/6 and 3/7
// Overview of operation
// RULE1: pair37 bit set: one idle cycle, space-3 select negated, between space-3 accesses.
// RULE2: pair37 bit also idles 3-to-7, 7-to-7 and 7-to-3 accesses.
// RULE3: pair26 bit set: one idle cycle, space-2 select negated, between space-2 accesses.
// RULE4: pair26 bit also idles 2-to-6, 6-to-6 and 6-to-2 accesses.
// RULE5: pair bit 0 inserts no idle cycle, 1 inserts exactly one.
// RULE6: pair37 bit 7 and pair26 bit 6 read/write, both reset to one.
// RULE7: write after read uses larger of read-to-write count and consecutive setting.
// RULE8: two-bit read-to-write field gives zero to three idles after a read.
// RULE9: access leaving the pair does not get that pair's consecutive idle.
`timescale 1ns/1ps
`default_nettype none
module bus_idle_cycle_insertion #(
  parameter int cfg_w = 8
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // configuration write
  input wire logic i_cfg_we,
  input wire logic [cfg_w-1:0] i_cfg_wdata,
  input wire logic i_rtw_we,
  input wire logic [idle_insert_pkg::pair_idx_w-1:0] i_rtw_pair,
  input wire logic [1:0] i_rtw_wdata,
  // access request from the processor side
  input wire logic i_req,
  input wire logic [2:0] i_space,
  input wire logic i_write,
  // request accepted
  output logic o_ack,
  // external bus strobes: selects active low, idle marker active high
  output logic [idle_insert_pkg::num_spaces-1:0] o_chip_select_n,
  output logic o_idle,
  // configuration readback
  output logic [cfg_w-1:0] o_cfg_rdata,
  output logic [1:0] o_rtw_pair37,
  output logic [1:0] o_rtw_pair26
);
  typedef enum logic [1:0] {st_ready, st_access, st_idle} state_t;
  state_t state;
  state_t next_state;
  logic pair37_idle_enable;
  logic pair26_idle_enable;
  logic [1:0] rtw37;
  logic [1:0] rtw26;
  logic prev_valid;
  logic [2:0] prev_space;
  logic prev_read;
  logic [1:0] idle_left;
  wire logic [1:0] need;
  wire logic take_now;
  wire logic [1:0] next_idle_left;
  wire logic [idle_insert_pkg::num_spaces-1:0] next_cs_n;
  wire logic [cfg_w-1:0] cfg_view;
  wire logic rtw37_hit;
  wire logic rtw26_hit;
  wire logic idle_start;
  wire logic idle_step;
  wire logic idle_done;
  wire logic enter_access;
  wire logic enter_idle;

  idle_need_calc u_need (
    .i_prev_valid(prev_valid),
    .i_prev_space(prev_space),
    .i_prev_read(prev_read),
    .i_next_space(i_space),
    .i_next_write(i_write),
    .i_pair37_idle_enable(pair37_idle_enable),
    .i_pair26_idle_enable(pair26_idle_enable),
    .i_rtw_pair37(rtw37),
    .i_rtw_pair26(rtw26),
    .o_need(need)
  );

  // request taken at once when no idle owed, otherwise idles first
  assign take_now = i_req && (need == 2'h0);
  assign next_idle_left = (state == st_idle) ? idle_left - 2'h1 : need - 2'h1;

  always_comb begin
    next_state = state;
    case (state)
      st_ready, st_access: begin
        if (i_req) begin
          next_state = take_now ? st_access : st_idle; // [RULE7]
        end else begin
          next_state = st_ready;
        end
      end
      st_idle: begin
        if (idle_left == 2'h0) begin
          next_state = st_ready;
        end
      end
      default: next_state = st_ready;
    endcase
  end

  // select asserted only during the access cycle, negated in idles
  generate
    for (genvar s = 0; s < idle_insert_pkg::num_spaces; s++) begin : g_cs
      assign next_cs_n[s] = !(enter_access && (i_space == 3'(s))); // [RULE1] [RULE3]
    end
  endgenerate

  // readback view of the two pair bits, spare bits zero
  generate
    for (genvar b = 0; b < cfg_w; b++) begin : g_cfg
      if (b == idle_insert_pkg::pair37_bit) begin : g_b37
        assign cfg_view[b] = pair37_idle_enable; // [RULE6]
      end else if (b == idle_insert_pkg::pair26_bit) begin : g_b26
        assign cfg_view[b] = pair26_idle_enable; // [RULE6]
      end else begin : g_spare
        assign cfg_view[b] = 1'b0;
      end
    end
  endgenerate

  // read-to-write count write strobes
  assign rtw37_hit = i_rtw_we && (i_rtw_pair == idle_insert_pkg::pair37_idx);
  assign rtw26_hit = i_rtw_we && (i_rtw_pair == idle_insert_pkg::pair26_idx);
  // sequencer decode
  assign idle_start = i_req && (state != st_idle) && !take_now;
  assign idle_step = (state == st_idle) && (idle_left != 2'h0);
  assign idle_done = (state == st_idle) && (idle_left == 2'h0);
  assign enter_access = (next_state == st_access);
  assign enter_idle = (next_state == st_idle);

  // pair idle enables, both set by reset
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      pair37_idle_enable <= idle_insert_pkg::pair37_idle_reset; // [RULE6]
    end else if (i_cfg_we) begin
      pair37_idle_enable <= i_cfg_wdata[idle_insert_pkg::pair37_bit]; // [RULE6]
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      pair26_idle_enable <= idle_insert_pkg::pair26_idle_reset; // [RULE6]
    end else if (i_cfg_we) begin
      pair26_idle_enable <= i_cfg_wdata[idle_insert_pkg::pair26_bit]; // [RULE6]
    end
  end

  // read-to-write counts per pair
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rtw37 <= idle_insert_pkg::rw_idle_reset; // [RULE8]
    end else if (rtw37_hit) begin
      rtw37 <= i_rtw_wdata; // [RULE8]
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rtw26 <= idle_insert_pkg::rw_idle_reset; // [RULE8]
    end else if (rtw26_hit) begin
      rtw26 <= i_rtw_wdata; // [RULE8]
    end
  end

  // state register
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state <= st_ready;
    end else begin
      state <= next_state;
    end
  end

  // idle countdown, loaded with need less one
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      idle_left <= 2'h0;
    end else if (idle_start || idle_step) begin
      idle_left <= next_idle_left; // [RULE7]
    end
  end

  // history of the last access, dropped after an idle run
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      prev_valid <= 1'b0;
    end else if (enter_access) begin
      prev_valid <= 1'b1;
    end else if (idle_done) begin
      prev_valid <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      prev_space <= 3'h0;
      prev_read <= 1'b0;
    end else if (enter_access) begin
      prev_space <= i_space;
      prev_read <= !i_write;
    end
  end

  // access strobe and selects
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_ack <= 1'b0;
      o_chip_select_n <= '1;
    end else begin
      o_ack <= enter_access;
      o_chip_select_n <= next_cs_n; // [RULE1] [RULE3]
    end
  end

  // idle marker
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_idle <= 1'b0;
    end else begin
      o_idle <= enter_idle; // [RULE5]
    end
  end

  // configuration readback
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_cfg_rdata <= '0;
      o_rtw_pair37 <= idle_insert_pkg::rw_idle_reset;
      o_rtw_pair26 <= idle_insert_pkg::rw_idle_reset;
    end else begin
      o_cfg_rdata <= cfg_view; // [RULE6]
      o_rtw_pair37 <= rtw37;
      o_rtw_pair26 <= rtw26;
    end
  end
endmodule // bus_idle_cycle_insertion
`default_nettype wire

// *** sim/space_memory_model.sv ***
// memory model that tallies chip-select accesses
`timescale 1ns/1ps
`default_nettype none
module space_memory_model (
  // bus side
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_chip_select_n,
  // tally
  output logic [7:0] o_access_count
);
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) o_access_count <= 8'h00;
    else if (i_chip_select_n != 8'hff) o_access_count <= o_access_count + 8'h01;
  end
endmodule // space_memory_model
`default_nettype wire

// *** sim/bus_idle_cycle_insertion_assertions.sv ***
// assertion checker for the idle-cycle insertion block
`timescale 1ns/1ps
`default_nettype none
module bus_idle_cycle_insertion_assertions #(
  parameter int cfg_w = 8
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // watched ports
  input wire logic i_cfg_we,
  input wire logic [cfg_w-1:0] i_cfg_wdata,
  input wire logic o_ack,
  input wire logic [idle_insert_pkg::num_spaces-1:0] o_chip_select_n,
  input wire logic o_idle,
  input wire logic [cfg_w-1:0] o_cfg_rdata
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  logic [2:0] idle_run;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n || !o_idle) idle_run <= 3'h0;
    else idle_run <= idle_run + 3'h1;
  end
  wire logic acc37;
  wire logic acc26;
  assign acc37 = o_ack && !(o_chip_select_n[3] && o_chip_select_n[7]);
  assign acc26 = o_ack && !(o_chip_select_n[2] && o_chip_select_n[6]);
  sequence s_access;
    o_ack && o_chip_select_n != 8'hff;
  endsequence
  property p_cfg_kept;
    i_cfg_we |-> ##2 o_cfg_rdata == ($past(i_cfg_wdata, 2) & 8'hc0);
  endproperty
  a_pair37_gap: assert property (acc37 && o_cfg_rdata[7] |=> !acc37)
    else $error("no idle between pair 3/7 accesses");
  a_pair26_gap: assert property (acc26 && o_cfg_rdata[6] |=> !acc26)
    else $error("no idle between pair 2/6 accesses");
  a_select_with_ack: assert property (o_chip_select_n != 8'hff |-> o_ack)
    else $error("select without ack");
  a_select_onehot: assert property (s_access |-> $onehot(~o_chip_select_n))
    else $error("select not one-hot");
  a_idle_negated: assert property (o_idle |-> o_chip_select_n == 8'hff && !o_ack)
    else $error("select during idle");
  a_idle_bound: assert property (!(o_idle && idle_run == 3'h3))
    else $error("idle run too long");
  a_plain_space: assert property (s_access ##0 !(&{o_chip_select_n[5:4],
    o_chip_select_n[1:0]}) |=> !o_idle)
    else $error("idle after other space");
  a_cfg_kept: assert property (p_cfg_kept)
    else $error("config bits lost");
  a_cfg_spare: assert property (o_cfg_rdata[5:0] == 6'h00)
    else $error("spare config bits set");
endmodule // bus_idle_cycle_insertion_assertions
bind bus_idle_cycle_insertion bus_idle_cycle_insertion_assertions #(.cfg_w(cfg_w)) chk_u (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cfg_we(i_cfg_we), .i_cfg_wdata(i_cfg_wdata),
  .o_ack(o_ack), .o_chip_select_n(o_chip_select_n), .o_idle(o_idle),
  .o_cfg_rdata(o_cfg_rdata));
`default_nettype wire

// *** sim/bus_idle_cycle_insertion_tb.sv ***
// self-checking bench for the idle-cycle insertion block
`timescale 1ns/1ps
`default_nettype none
module bus_idle_cycle_insertion_tb;
  logic i_mclk, i_rst_n, i_cfg_we, i_rtw_we, i_req, i_write, o_ack, o_idle, pread;
  logic [7:0] i_cfg_wdata, o_chip_select_n, o_cfg_rdata, tally, total;
  logic [1:0] i_rtw_pair, i_rtw_wdata, o_rtw_pair37, o_rtw_pair26, cw37, cw26, rtw37, rtw26;
  logic [2:0] i_space, pspace;
  int err_count, cmp_count;
  bus_idle_cycle_insertion dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cfg_we(i_cfg_we),
    .i_cfg_wdata(i_cfg_wdata), .i_rtw_we(i_rtw_we), .i_rtw_pair(i_rtw_pair),
    .i_rtw_wdata(i_rtw_wdata), .i_req(i_req), .i_space(i_space), .i_write(i_write),
    .o_ack(o_ack), .o_chip_select_n(o_chip_select_n), .o_idle(o_idle),
    .o_cfg_rdata(o_cfg_rdata), .o_rtw_pair37(o_rtw_pair37), .o_rtw_pair26(o_rtw_pair26));
  space_memory_model mem_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_chip_select_n(o_chip_select_n), .o_access_count(tally));
  initial begin
    i_mclk = 1'h0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("mismatches %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [1:0] need(input logic [2:0] s, input logic w);
    logic [1:0] cw, rtw;
    cw = pspace[0] ? cw37 : cw26;
    rtw = pspace[0] ? rtw37 : rtw26;
    if (!pspace[1]) return 2'h0;
    if (s[1:0] != pspace[1:0]) return pread ? rtw : 2'h0;
    if (pread && w) return (rtw > cw) ? rtw : cw;
    return cw;
  endfunction
  task automatic access(input logic [2:0] s, input logic w);
    logic [7:0] idles;
    int n;
    idles = 8'h00;
    n = 0;
    @(negedge i_mclk);
    i_req = 1'h1;
    i_space = s;
    i_write = w;
    do begin
      @(posedge i_mclk);
      #1;
      if (o_idle === 1'h1) idles++;
      n++;
    end while (o_ack !== 1'h1 && n < 20);
    if (n >= 20) begin
      err_count++;
      end_of_test();
    end else begin
      check(idles, {6'h00, need(s, w)});
      check(o_chip_select_n, ~(8'h01 << s));
      pspace = s;
      pread = ~w;
      total++;
    end
  endtask
  task automatic play(input logic [31:0] seq, input int k);
    for (int i = 0; i < k; i++) access(seq[4*i+:3], seq[4*i+3]);
    @(negedge i_mclk);
    i_req = 1'h0;
  endtask
  task automatic setup(input logic [7:0] cfg, input logic [1:0] r37, input logic [1:0] r26);
    @(negedge i_mclk);
    {i_cfg_we, i_cfg_wdata, i_rtw_we, i_rtw_pair, i_rtw_wdata} = {1'h1, cfg, 3'h7, r37};
    @(negedge i_mclk);
    {i_cfg_we, i_rtw_pair, i_rtw_wdata} = {1'h0, 2'h2, r26};
    @(negedge i_mclk);
    i_rtw_we = 1'h0;
    repeat (2) @(negedge i_mclk);
    check(o_cfg_rdata, cfg & 8'hc0);
    check({o_rtw_pair37, o_rtw_pair26}, {4'h0, r37, r26});
    {cw37, cw26, rtw37, rtw26} = {1'h0, cfg[7], 1'h0, cfg[6], r37, r26};
  endtask
  task automatic reset_defaults;
    check(o_cfg_rdata, 8'hc0);
    check({o_rtw_pair37, o_rtw_pair26}, 8'h0f);
    play(32'h08e3_f733, 7);
  endtask
  task automatic pairs_mixed;
    setup(8'hff, 2'h0, 2'h2);
    play(32'h852e_e2f3, 8);
  endtask
  task automatic pairs_off;
    setup(8'h00, 2'h0, 2'h2);
    play(32'h86a2_f7bb, 8);
  endtask
  initial begin
    {i_rst_n, i_cfg_we, i_rtw_we, i_req, i_write, pread, i_cfg_wdata, total} = 22'h0;
    {i_rtw_pair, i_rtw_wdata, i_space, pspace, cw37, cw26, rtw37, rtw26} = 18'h0_015f;
    err_count = 0;
    cmp_count = 0;
    repeat (2) @(negedge i_mclk);
    i_rst_n = 1'h1;
    @(negedge i_mclk);
    reset_defaults();
    pairs_mixed();
    pairs_off();
    repeat (2) @(negedge i_mclk);
    check(tally, total);
    end_of_test();
  end
endmodule // bus_idle_cycle_insertion_tb
`default_nettype wire
